// ---- logic/tsh_inst.sv ----
// Instrument end: accessory bus master and part sorter port driver
module tsh_inst
	import tsh_pkg::*;
#(
	parameter int STROBE_CYCLES = STROBE_CYC,
	parameter int LONG_CYCLES = LONG_CYC
)(
	// Clock and reset
	input wire logic clk,
	input wire logic nrst,
	// Pins
	tsh_if.inst pins,
	// Accessory bus requests from the controller
	input wire logic bus_req,
	input wire logic bus_read,
	input wire logic [AD_W-1:0] bus_addr,
	input wire logic [AD_W-1:0] bus_wdata,
	output logic bus_busy,
	output logic bus_done,
	output logic [AD_W-1:0] bus_rdata,
	// Sweep control
	input wire logic sweep_start,
	input wire logic sweep_finish,
	output logic sweep_run,
	output logic sweep_aborted,
	output logic power_press,
	// Sorter port writes, remote command path only
	input wire logic remote_wr,
	input wire logic [WIDE_W-1:0] rem_a,
	input wire logic [WIDE_W-1:0] rem_b,
	input wire logic [NIB_W-1:0] rem_c,
	input wire logic [NIB_W-1:0] rem_d,
	input wire logic rem_c_out,
	input wire logic rem_d_out,
	input wire logic [GEN_W-1:0] rem_gen,
	input wire logic remote_verdict_wr,
	input wire logic rem_pass,
	input wire logic rem_pass_polarity,
	output logic [NIB_W-1:0] c_in,
	output logic [NIB_W-1:0] d_in
);

	tsh_bus_e st_r;
	logic [CNT_W-1:0] bus_cnt_r;
	logic [CNT_W-1:0] irq_cnt_r;
	logic [CNT_W-1:0] dw_cnt_r;
	logic [CNT_W-1:0] vw_cnt_r;
	logic [CNT_W-1:0] sd_cnt_r;
	logic [AD_W-1:0] ad_o_r;
	logic ad_oe_r, rd_r;
	logic [GEN_W-1:0] gen_pend_r;
	logic lat_d_r, pwr_d_r;

	// ****************************************
	// Fixed pins and accessory bus drive
	// ****************************************
	assign {pins.accessory_select_bit3, pins.accessory_select_bits_mid,
		pins.accessory_select_bit0} = SEL_TIED;
	assign pins.ad_inst_o = ad_o_r;
	assign pins.ad_inst_oe = {AD_W{ad_oe_r}};

	// ****************************************
	// Accessory bus master: address phase, gap, data phase
	// ****************************************
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			st_r <= TSH_IDLE;
			bus_cnt_r <= '0;
			ad_o_r <= '0;
			ad_oe_r <= 1'b0;
			rd_r <= DIR_READ;
			pins.address_strobe_low <= IDLE_HIGH;
			pins.data_strobe_low <= IDLE_HIGH;
			pins.read_not_write <= DIR_READ;
			bus_busy <= 1'b0;
			bus_done <= 1'b0;
			bus_rdata <= '0;
		end else begin
			bus_done <= 1'b0;
			unique case (st_r)
			TSH_IDLE: begin
				if (bus_req) begin
					st_r <= TSH_ADDR;
					bus_busy <= 1'b1;
					rd_r <= bus_read;
					pins.read_not_write <= bus_read ? DIR_READ
						: DIR_WRITE;
					ad_o_r <= bus_addr;
					ad_oe_r <= 1'b1;
					pins.address_strobe_low <= 1'b0;
					bus_cnt_r <= '0;
				end
			end
			TSH_ADDR: begin
				bus_cnt_r <= bus_cnt_r + 1'b1;
				if (tsh_done(bus_cnt_r + 1'b1, STROBE_CYCLES)) begin
					pins.address_strobe_low <= IDLE_HIGH;
					st_r <= TSH_GAP;
				end
			end
			TSH_GAP: begin
				ad_o_r <= bus_wdata;
				ad_oe_r <= !rd_r;
				pins.data_strobe_low <= 1'b0;
				bus_cnt_r <= '0;
				st_r <= TSH_DATA;
			end
			TSH_DATA: begin
				bus_cnt_r <= bus_cnt_r + 1'b1;
				if (tsh_done(bus_cnt_r + 1'b1, STROBE_CYCLES)) begin
					pins.data_strobe_low <= IDLE_HIGH;
					if (rd_r)
						bus_rdata <= pins.ad;
					ad_oe_r <= 1'b0;
					bus_busy <= 1'b0;
					bus_done <= 1'b1;
					st_r <= TSH_IDLE;
				end
			end
			endcase
		end
	end

	// ****************************************
	// Sweep control: holdoff, abort filter, done pulse
	// ****************************************
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			sweep_run <= 1'b0;
			sweep_aborted <= 1'b0;
			irq_cnt_r <= '0;
			sd_cnt_r <= '0;
			pins.sweep_done_low <= IDLE_HIGH;
		end else begin
			sweep_aborted <= 1'b0;
			// Count down first so that a new finish reloads the full length
			if (sd_cnt_r != '0)
				sd_cnt_r <= sd_cnt_r - 1'b1;
			if (!pins.irq_low)
				irq_cnt_r <= (irq_cnt_r == CNT_W'(LONG_CYCLES)) ? irq_cnt_r
					: irq_cnt_r + 1'b1;
			else
				irq_cnt_r <= '0;
			if (sweep_run && irq_cnt_r == CNT_W'(LONG_CYCLES - 1)) begin
				sweep_run <= 1'b0;
				sweep_aborted <= 1'b1;
			end else if (sweep_run && sweep_finish && pins.holdoff_low) begin
				sweep_run <= 1'b0;
				sd_cnt_r <= CNT_W'(LONG_CYCLES);
			end else if (!sweep_run && sweep_start && pins.holdoff_low
				&& irq_cnt_r == '0)
				sweep_run <= 1'b1;
			pins.sweep_done_low <= !(sd_cnt_r > CNT_W'(1)
				|| (sweep_run && sweep_finish && pins.holdoff_low
				&& irq_cnt_r != CNT_W'(LONG_CYCLES - 1)));
		end
	end

	// ****************************************
	// Sorter ports: remote writes, then data write strobe
	// ****************************************
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			pins.port_a <= '0;
			pins.port_b <= '0;
			pins.port_c_o <= '0;
			pins.port_d_o <= '0;
			pins.port_c_oe <= '0;
			pins.port_d_oe <= '0;
			pins.port_c_dir <= 1'b0;
			pins.port_d_dir <= 1'b0;
			pins.data_wr_strobe_low <= IDLE_HIGH;
			dw_cnt_r <= '0;
			gen_pend_r <= '0;
		end else begin
			if (remote_wr && dw_cnt_r == '0) begin
				pins.port_a <= rem_a;
				pins.port_b <= rem_b;
				pins.port_c_o <= rem_c;
				pins.port_d_o <= rem_d;
				pins.port_c_oe <= {NIB_W{rem_c_out}};
				pins.port_d_oe <= {NIB_W{rem_d_out}};
				pins.port_c_dir <= rem_c_out;
				pins.port_d_dir <= rem_d_out;
				gen_pend_r <= rem_gen;
				dw_cnt_r <= CNT_W'(STROBE_CYCLES + 1);
			end else if (dw_cnt_r != '0)
				dw_cnt_r <= dw_cnt_r - 1'b1;
			// Strobe falls one cycle after data, rises before data may move
			pins.data_wr_strobe_low <= !(dw_cnt_r > CNT_W'(1));
		end
	end

	// ****************************************
	// Verdict output with its strobe, general outs, power key
	// ****************************************
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			pins.verdict <= 1'b0;
			pins.verdict_wr_strobe_low <= IDLE_HIGH;
			pins.sorter_general_outs <= '0;
			vw_cnt_r <= '0;
			lat_d_r <= IDLE_HIGH;
			pwr_d_r <= IDLE_HIGH;
			power_press <= 1'b0;
			c_in <= '0;
			d_in <= '0;
		end else begin
			if (remote_verdict_wr && vw_cnt_r == '0) begin
				pins.verdict <= rem_pass ^ rem_pass_polarity;
				vw_cnt_r <= CNT_W'(STROBE_CYCLES + 1);
			end else if (vw_cnt_r != '0)
				vw_cnt_r <= vw_cnt_r - 1'b1;
			pins.verdict_wr_strobe_low <= !(vw_cnt_r > CNT_W'(1));
			lat_d_r <= pins.sorter_latch_request;
			if (lat_d_r && !pins.sorter_latch_request)
				pins.sorter_general_outs <= gen_pend_r;
			pwr_d_r <= pins.power_key_low;
			power_press <= pwr_d_r && !pins.power_key_low;
			c_in <= pins.port_c;
			d_in <= pins.port_d;
		end
	end

endmodule : tsh_inst

// ---- pkg/tsh_pkg.sv ----
// Shared constants and types for the accessory bus and part sorter port
package tsh_pkg;

	// ****************************************
	// Bus and port widths
	// ****************************************
	localparam int AD_W = 13;
	localparam int SEL_W = 4;
	localparam int MAX_SETS = 16;
	localparam int WIDE_W = 8;
	localparam int NIB_W = 4;
	localparam int GEN_W = 2;

	// ****************************************
	// Timing: least lengths in cycles at 40 MHz
	// ****************************************
	localparam int CLK_MHZ = 40;
	localparam int STROBE_NS = 1000;
	localparam int LONG_NS = 10000;
	localparam int NS_PER_US = 1000;
	localparam int STROBE_CYC = (STROBE_NS * CLK_MHZ + NS_PER_US - 1)
		/ NS_PER_US;
	localparam int LONG_CYC = (LONG_NS * CLK_MHZ + NS_PER_US - 1)
		/ NS_PER_US;
	localparam int CNT_W = 10;

	// ****************************************
	// Resting values
	// ****************************************
	localparam logic [SEL_W-1:0] SEL_TIED = 4'h0;
	localparam logic IDLE_HIGH = 1'b1;
	localparam logic DIR_READ = 1'b1;
	localparam logic DIR_WRITE = 1'b0;

	// ****************************************
	// Accessory bus master states
	// ****************************************
	typedef enum logic [1:0] {
		TSH_IDLE = 2'b00,
		TSH_ADDR = 2'b01,
		TSH_GAP = 2'b10,
		TSH_DATA = 2'b11
	} tsh_bus_e;

	// Least-time counter check, used by the instrument end only
	function automatic logic tsh_done(input logic [CNT_W-1:0] cnt,
		input int lim);
		return cnt >= lim[CNT_W-1:0];
	endfunction : tsh_done

endpackage : tsh_pkg

// ---- pkg/tsh_if.sv ----
// Pins between the instrument and an external test set or part sorter
interface tsh_if;
	import tsh_pkg::*;

	// Accessory bus, shared lines as in, out and enable per end
	logic [AD_W-1:0] ad_inst_o;
	logic [AD_W-1:0] ad_inst_oe;
	logic [AD_W-1:0] ad_set_o;
	logic [AD_W-1:0] ad_set_oe;
	logic [AD_W-1:0] ad;
	logic address_strobe_low;
	logic data_strobe_low;
	logic read_not_write;
	logic accessory_select_bit0;
	logic [1:0] accessory_select_bits_mid;
	logic accessory_select_bit3;
	logic holdoff_low;
	logic irq_low_oe;
	logic irq_low;

	// Part sorter port
	logic sorter_latch_request;
	logic [GEN_W-1:0] sorter_general_outs;
	logic [WIDE_W-1:0] port_a;
	logic [WIDE_W-1:0] port_b;
	logic [NIB_W-1:0] port_c_o;
	logic [NIB_W-1:0] port_c_oe;
	logic [NIB_W-1:0] port_d_o;
	logic [NIB_W-1:0] port_d_oe;
	logic [NIB_W-1:0] port_c_ext_o;
	logic [NIB_W-1:0] port_c_ext_oe;
	logic [NIB_W-1:0] port_d_ext_o;
	logic [NIB_W-1:0] port_d_ext_oe;
	logic [NIB_W-1:0] port_c;
	logic [NIB_W-1:0] port_d;
	logic port_c_dir;
	logic port_d_dir;
	logic data_wr_strobe_low;
	logic verdict;
	logic verdict_wr_strobe_low;
	logic sweep_done_low;
	logic power_key_low_oe;
	logic power_key_low;

	// Wire resolution: driven bits win, undriven pulled high (wired-OR low)
	assign ad = (ad_inst_o & ad_inst_oe) | (ad_set_o & ad_set_oe)
		| ~(ad_inst_oe | ad_set_oe);
	assign irq_low = ~irq_low_oe;
	assign power_key_low = ~power_key_low_oe;
	assign port_c = (port_c_o & port_c_oe) | (port_c_ext_o & port_c_ext_oe)
		| ~(port_c_oe | port_c_ext_oe);
	assign port_d = (port_d_o & port_d_oe) | (port_d_ext_o & port_d_ext_oe)
		| ~(port_d_oe | port_d_ext_oe);

	modport inst (
		output ad_inst_o, ad_inst_oe, address_strobe_low, data_strobe_low,
		output read_not_write, accessory_select_bit0,
		output accessory_select_bits_mid, accessory_select_bit3,
		input ad, holdoff_low, irq_low, sorter_latch_request, power_key_low,
		output sorter_general_outs, port_a, port_b, port_c_o, port_c_oe,
		output port_d_o, port_d_oe, port_c_dir, port_d_dir,
		output data_wr_strobe_low, verdict, verdict_wr_strobe_low,
		output sweep_done_low,
		input port_c, port_d
	);

	modport ext (
		output ad_set_o, ad_set_oe, holdoff_low, irq_low_oe,
		output sorter_latch_request, power_key_low_oe,
		output port_c_ext_o, port_c_ext_oe, port_d_ext_o, port_d_ext_oe,
		input ad, address_strobe_low, data_strobe_low, read_not_write,
		input accessory_select_bit0, accessory_select_bits_mid,
		input accessory_select_bit3, irq_low, power_key_low,
		input sorter_general_outs, port_a, port_b, port_c, port_d,
		input port_c_dir, port_d_dir, data_wr_strobe_low, verdict,
		input verdict_wr_strobe_low, sweep_done_low
	);

endinterface : tsh_if

// ---- logic/tsh_ext.sv ----
// External test set and part sorter end of the rear-panel link
module tsh_ext
	import tsh_pkg::*;
(
	// Clock and reset
	input wire logic clk,
	input wire logic nrst,
	// Pins
	tsh_if.ext pins,
	// User side: test set register
	input wire logic [AD_W-1:0] set_rd_data,
	output logic [AD_W-1:0] set_addr,
	output logic [AD_W-1:0] set_wr_data,
	output logic set_wr_pulse,
	// User side: requests
	input wire logic hold_sweep,
	input wire logic abort_req,
	input wire logic latch_req,
	input wire logic power_req,
	input wire logic [NIB_W-1:0] c_drive,
	input wire logic [NIB_W-1:0] d_drive,
	// User side: observed events
	output logic data_seen,
	output logic verdict_seen,
	output logic done_seen
);

	logic [CNT_W-1:0] irq_cnt_r;
	logic [CNT_W-1:0] lat_cnt_r;
	logic [CNT_W-1:0] pwr_cnt_r;
	logic as_d_r, ds_d_r, dw_d_r, vw_d_r, sd_d_r;

	// ****************************************
	// Accessory bus: capture address and data on strobe fall
	// ****************************************
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			set_addr <= '0;
			set_wr_data <= '0;
			set_wr_pulse <= 1'b0;
			as_d_r <= IDLE_HIGH;
			ds_d_r <= IDLE_HIGH;
		end else begin
			as_d_r <= pins.address_strobe_low;
			ds_d_r <= pins.data_strobe_low;
			set_wr_pulse <= 1'b0;
			// The master releases the lines as its strobe rises, so take
			// them on the fall while they are surely driven
			if (!pins.address_strobe_low && as_d_r)
				set_addr <= pins.ad;
			if (!pins.data_strobe_low && ds_d_r
				&& pins.read_not_write == DIR_WRITE) begin
				set_wr_data <= pins.ad;
				set_wr_pulse <= 1'b1;
			end
		end
	end

	// Drive read data only during a read data phase; all selects are zero
	assign pins.ad_set_o = set_rd_data;
	assign pins.ad_set_oe = {AD_W{!pins.data_strobe_low
		&& pins.read_not_write == DIR_READ}};

	// ****************************************
	// Held-low requests, each stretched to its least length
	// ****************************************
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			irq_cnt_r <= '0;
			lat_cnt_r <= '0;
			pwr_cnt_r <= '0;
		end else begin
			if (abort_req && irq_cnt_r == '0)
				irq_cnt_r <= CNT_W'(LONG_CYC);
			else if (irq_cnt_r != '0)
				irq_cnt_r <= irq_cnt_r - 1'b1;
			if (latch_req && lat_cnt_r == '0)
				lat_cnt_r <= CNT_W'(STROBE_CYC);
			else if (lat_cnt_r != '0)
				lat_cnt_r <= lat_cnt_r - 1'b1;
			if (power_req && pwr_cnt_r == '0)
				pwr_cnt_r <= CNT_W'(STROBE_CYC);
			else if (pwr_cnt_r != '0)
				pwr_cnt_r <= pwr_cnt_r - 1'b1;
		end
	end

	assign pins.irq_low_oe = irq_cnt_r != '0;
	assign pins.sorter_latch_request = !(lat_cnt_r != '0);
	assign pins.power_key_low_oe = pwr_cnt_r != '0;
	assign pins.holdoff_low = !hold_sweep;
	assign pins.port_c_ext_o = c_drive;
	assign pins.port_c_ext_oe = {NIB_W{!pins.port_c_dir}};
	assign pins.port_d_ext_o = d_drive;
	assign pins.port_d_ext_oe = {NIB_W{!pins.port_d_dir}};

	// ****************************************
	// Strobe watchers: one pulse on each rising edge
	// ****************************************
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			dw_d_r <= IDLE_HIGH;
			vw_d_r <= IDLE_HIGH;
			sd_d_r <= IDLE_HIGH;
			data_seen <= 1'b0;
			verdict_seen <= 1'b0;
			done_seen <= 1'b0;
		end else begin
			dw_d_r <= pins.data_wr_strobe_low;
			vw_d_r <= pins.verdict_wr_strobe_low;
			sd_d_r <= pins.sweep_done_low;
			data_seen <= pins.data_wr_strobe_low && !dw_d_r;
			verdict_seen <= pins.verdict_wr_strobe_low && !vw_d_r;
			done_seen <= pins.sweep_done_low && !sd_d_r;
		end
	end

endmodule : tsh_ext

// ---- sim/tsh_monitor.sv ----
// Pin-level checker for the instrument end of the rear-panel link
module tsh_monitor
	import tsh_pkg::*;
#(
	parameter int STROBE_CYCLES = STROBE_CYC,
	parameter int LONG_CYCLES = LONG_CYC
)(
	// Clock and reset
	input wire logic clk,
	input wire logic nrst,
	// Accessory bus
	input wire logic [AD_W-1:0] ad_inst_oe,
	input wire logic address_strobe_low,
	input wire logic data_strobe_low,
	input wire logic read_not_write,
	input wire logic accessory_select_bit0,
	input wire logic [1:0] accessory_select_bits_mid,
	input wire logic accessory_select_bit3,
	// Sorter port
	input wire logic sorter_latch_request,
	input wire logic [GEN_W-1:0] sorter_general_outs,
	input wire logic [WIDE_W-1:0] port_a,
	input wire logic [NIB_W-1:0] port_c_oe,
	input wire logic port_c_dir,
	input wire logic data_wr_strobe_low,
	input wire logic verdict_wr_strobe_low,
	input wire logic sweep_done_low
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge clk); endclocking
	default disable iff (!nrst);

	// ****************************************
	// Low-time counters
	// ****************************************
	logic [4:0] stb;
	logic [CNT_W-1:0] lo_cnt [5];
	assign stb = {sweep_done_low, verdict_wr_strobe_low,
		data_wr_strobe_low, data_strobe_low, address_strobe_low};
	// Cycles each strobe has stayed low, cleared while high
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			for (int i = 0; i < 5; i++) begin
				lo_cnt[i] <= '0;
			end
		end else begin
			for (int i = 0; i < 5; i++) begin
				lo_cnt[i] <= stb[i] ? '0 : lo_cnt[i] + 1'b1;
			end
		end
	end

	// ****************************************
	// Assertions
	// ****************************************
	property p_as_min;
		$rose(address_strobe_low) |-> lo_cnt[0] >= STROBE_CYCLES;
	endproperty
	a_as_min: assert property (p_as_min)
		else $error("address strobe too short");
	property p_ds_min;
		$rose(data_strobe_low) |-> lo_cnt[1] >= STROBE_CYCLES;
	endproperty
	a_ds_min: assert property (p_ds_min)
		else $error("data strobe too short");
	property p_dws_min;
		$rose(data_wr_strobe_low) |-> lo_cnt[2] >= STROBE_CYCLES;
	endproperty
	a_dws_min: assert property (p_dws_min)
		else $error("data write strobe too short");
	property p_vws_min;
		$rose(verdict_wr_strobe_low) |-> lo_cnt[3] >= STROBE_CYCLES;
	endproperty
	a_vws_min: assert property (p_vws_min)
		else $error("verdict write strobe too short");
	property p_done_min;
		$rose(sweep_done_low) |-> lo_cnt[4] >= LONG_CYCLES;
	endproperty
	a_done_min: assert property (p_done_min)
		else $error("sweep done too short");
	property p_sel_tied;
		{accessory_select_bit3, accessory_select_bits_mid,
			accessory_select_bit0} == SEL_TIED;
	endproperty
	a_sel_tied: assert property (p_sel_tied)
		else $error("select lines not low");
	property p_bus_dir;
		!data_strobe_low |-> ad_inst_oe == {AD_W{~read_not_write}};
	endproperty
	a_bus_dir: assert property (p_bus_dir)
		else $error("bus drive against direction");
	property p_port_dir;
		port_c_oe == {NIB_W{port_c_dir}};
	endproperty
	a_port_dir: assert property (p_port_dir)
		else $error("port drive against status");
	property p_data_hold;
		!data_wr_strobe_low |-> $stable(port_a);
	endproperty
	a_data_hold: assert property (p_data_hold)
		else $error("port changed under strobe");
	property p_gen_latch;
		$changed(sorter_general_outs) |-> !$past(sorter_latch_request);
	endproperty
	a_gen_latch: assert property (p_gen_latch)
		else $error("general outs changed unlatched");
	property p_reset_rest;
		$rose(nrst) |-> &stb && !port_c_dir;
	endproperty
	a_reset_rest: assert property (p_reset_rest)
		else $error("outputs not at rest after reset");

	// Main scenarios reached
	c_read: cover property ($rose(data_strobe_low) && read_not_write);
	c_verdict: cover property ($rose(verdict_wr_strobe_low));
	c_done: cover property ($rose(sweep_done_low));
endmodule : tsh_monitor

// ---- sim/test_set_and_handler_io_tb.sv ----
// Self-checking bench joining both ends of the rear-panel link
module test_set_and_handler_io_tb
	import tsh_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk = 1'b0;
	logic nrst = 1'b0;
	logic bus_req = 1'b0;
	logic bus_read = 1'b0;
	logic [AD_W-1:0] bus_addr = '0, bus_wdata = '0, set_rd_data = '0;
	logic [6:0] pl = '0; // Pulse-type inputs of both ends
	logic [WIDE_W-1:0] rem_a = '0, rem_b = '0;
	logic [NIB_W-1:0] rem_c = '0, rem_d = '0, c_drive = '0, d_drive = '0;
	logic [GEN_W-1:0] rem_gen = '0, gen_now = '0;
	logic rem_c_out = 1'b0, rem_d_out = 1'b0, hold_sweep = 1'b0;
	logic rem_pass = 1'b0, rem_pass_polarity = 1'b0;
	logic bus_busy, bus_done, sweep_run, sweep_aborted, power_press;
	logic [AD_W-1:0] bus_rdata, set_addr, set_wr_data;
	logic [NIB_W-1:0] c_in, d_in;
	logic set_wr_pulse, data_seen, verdict_seen, done_seen;
	logic [5:0] ev;
	logic [15:0] rnd = 16'h0010;
	int err_total = 0, total_checks = 0, cyc = 0, wr_cnt = 0;

	// ****************************************
	// Clock, link and ends
	// ****************************************
	assign ev = {power_press, sweep_aborted, done_seen, verdict_seen,
		data_seen, bus_done};
	always #12.5 clk = ~clk;
	tsh_if pins();
	tsh_inst i_tsh_inst (.clk, .nrst, .pins(pins.inst), .bus_req, .bus_read,
		.bus_addr, .bus_wdata, .bus_busy, .bus_done, .bus_rdata,
		.sweep_start(pl[0]), .sweep_finish(pl[1]), .sweep_run,
		.sweep_aborted, .power_press, .remote_wr(pl[5]), .rem_a, .rem_b,
		.rem_c, .rem_d, .rem_c_out, .rem_d_out, .rem_gen,
		.remote_verdict_wr(pl[6]), .rem_pass, .rem_pass_polarity, .c_in,
		.d_in);
	tsh_ext i_tsh_ext (.clk, .nrst, .pins(pins.ext), .set_rd_data,
		.set_addr, .set_wr_data, .set_wr_pulse, .hold_sweep,
		.abort_req(pl[2]), .latch_req(pl[3]), .power_req(pl[4]), .c_drive,
		.d_drive, .data_seen, .verdict_seen, .done_seen);
	tsh_monitor #(.STROBE_CYCLES(STROBE_CYC), .LONG_CYCLES(LONG_CYC))
	i_tsh_monitor (.clk, .nrst, .ad_inst_oe(pins.ad_inst_oe),
		.address_strobe_low(pins.address_strobe_low),
		.data_strobe_low(pins.data_strobe_low),
		.read_not_write(pins.read_not_write),
		.accessory_select_bit0(pins.accessory_select_bit0),
		.accessory_select_bits_mid(pins.accessory_select_bits_mid),
		.accessory_select_bit3(pins.accessory_select_bit3),
		.sorter_latch_request(pins.sorter_latch_request),
		.sorter_general_outs(pins.sorter_general_outs),
		.port_a(pins.port_a), .port_c_oe(pins.port_c_oe),
		.port_c_dir(pins.port_c_dir),
		.data_wr_strobe_low(pins.data_wr_strobe_low),
		.verdict_wr_strobe_low(pins.verdict_wr_strobe_low),
		.sweep_done_low(pins.sweep_done_low));

	// ****************************************
	// Helpers
	// ****************************************
	task automatic check(input logic [15:0] got, input logic [15:0] exp);
		total_checks++;
		if (got !== exp) begin
			err_total++;
			$display("mismatch at %0t: got %h want %h", $time, got, exp);
		end
	endtask : check
	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", total_checks, err_total);
		if (err_total == 0 && total_checks > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask : report_and_stop
	function automatic logic [15:0] lfsr(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction : lfsr
	// Expected resolved nibbles: driven end wins, other end drives inverse
	function automatic logic [15:0] exp_cd(input logic [15:0] r);
		logic [3:0] c, d;
		c = r[8] ? r[3:0] : ~r[3:0];
		d = r[8] ? ~r[7:4] : r[7:4];
		return {8'h00, d, c};
	endfunction : exp_cd
	task automatic pulse(input int k);
		@(posedge clk) pl[k] <= 1'b1;
		@(posedge clk) pl[k] <= 1'b0;
	endtask : pulse
	// Bounded wait for a one-cycle event
	task automatic wait_ev(input int k, input int lim);
		int n;
		n = 0;
		while (ev[k] !== 1'b1 && n < lim) begin
			@(posedge clk);
			n++;
		end
		check(16'(ev[k]), 16'h0001);
	endtask : wait_ev
	task automatic bus_xfer(input logic rd, input logic [AD_W-1:0] a, d);
		int w0;
		w0 = wr_cnt;
		@(posedge clk);
		bus_req <= 1'b1;
		bus_read <= rd;
		bus_addr <= a;
		bus_wdata <= d;
		set_rd_data <= d;
		@(posedge clk) bus_req <= 1'b0;
		repeat (2) @(posedge clk);
		#1 check(16'(pins.read_not_write), 16'(rd));
		check(16'(pins.address_strobe_low), 16'h0000);
		check(16'(bus_busy), 16'h0001);
		wait_ev(0, 2 * STROBE_CYC + 8);
		check(16'(bus_busy), 16'h0000);
		check(16'(set_addr), 16'(a));
		check(16'(rd ? bus_rdata : set_wr_data), 16'(d));
		check(16'(wr_cnt - w0), 16'(!rd));
	endtask : bus_xfer
	task automatic wr_port(input logic [15:0] r);
		@(posedge clk);
		{rem_b, rem_a} <= r;
		{rem_d, rem_c} <= r[7:0];
		{d_drive, c_drive} <= ~r[7:0];
		rem_c_out <= r[8];
		rem_d_out <= ~r[8];
		rem_gen <= r[10:9];
		pl[5] <= 1'b1;
		@(posedge clk) pl[5] <= 1'b0;
		wait_ev(1, STROBE_CYC + 8);
		check({pins.port_b, pins.port_a}, r);
		check(16'({pins.port_d, pins.port_c}), exp_cd(r));
		check(16'({d_in, c_in}), exp_cd(r));
		check(16'({pins.port_d_dir, pins.port_c_dir}),
			{14'h0, ~r[8], r[8]});
		check(16'(pins.sorter_general_outs), 16'(gen_now));
		pulse(3);
		repeat (STROBE_CYC) @(posedge clk);
		check(16'(pins.sorter_general_outs), 16'(r[10:9]));
		gen_now = r[10:9];
	endtask : wr_port

	// ****************************************
	// Main sequence
	// ****************************************
	initial begin
		repeat (5) @(posedge clk);
		nrst <= 1'b1;
		#1 check(16'({pins.address_strobe_low, pins.data_strobe_low,
			pins.data_wr_strobe_low, pins.verdict_wr_strobe_low,
			pins.sweep_done_low, pins.port_c_dir, pins.port_d_dir}),
			16'h007c);
		check(16'({pins.accessory_select_bit3, pins.accessory_select_bits_mid,
			pins.accessory_select_bit0}), 16'(SEL_TIED));
		bus_xfer(1'b0, 13'h1fff, 13'h0000);
		bus_xfer(1'b1, 13'h0000, 13'h1fff);
		for (int i = 0; i < 4; i++) begin
			rnd = lfsr(rnd);
			bus_xfer(rnd[0], rnd[12:0], rnd[15:3]);
		end
		$display("test bus transfers done");
		for (int i = 0; i < 3; i++) begin
			rnd = lfsr(rnd);
			wr_port(i == 0 ? 16'hffff : rnd);
		end
		$display("test sorter ports done");
		for (int i = 0; i < 4; i++) begin
			@(posedge clk);
			rem_pass <= i[0];
			rem_pass_polarity <= i[1];
			pl[6] <= 1'b1;
			@(posedge clk) pl[6] <= 1'b0;
			wait_ev(2, STROBE_CYC + 8);
			check(16'(pins.verdict), 16'(i[0] ^ i[1]));
		end
		$display("test verdict done");
		hold_sweep <= 1'b1;
		pulse(0);
		repeat (4) @(posedge clk);
		check(16'(sweep_run), 16'h0000);
		hold_sweep <= 1'b0;
		pulse(0);
		repeat (4) @(posedge clk);
		check(16'(sweep_run), 16'h0001);
		hold_sweep <= 1'b1;
		pulse(1);
		repeat (4) @(posedge clk);
		check(16'(sweep_run), 16'h0001);
		hold_sweep <= 1'b0;
		pulse(1);
		wait_ev(3, LONG_CYC + 20);
		check(16'(sweep_run), 16'h0000);
		pulse(0);
		repeat (4) @(posedge clk);
		pulse(2);
		wait_ev(4, LONG_CYC + 20);
		check(16'(sweep_run), 16'h0000);
		pulse(4);
		wait_ev(5, STROBE_CYC + 8);
		$display("test sweep and power done");
		report_and_stop();
	end

	// Count write pulses seen by the test set end
	always @(posedge clk) begin
		if (set_wr_pulse === 1'b1) begin
			wr_cnt++;
		end
	end

	// Cut a hang short
	always @(posedge clk) begin
		cyc++;
		if (cyc > 6000) begin
			err_total++;
			report_and_stop();
		end
	end
endmodule : test_set_and_handler_io_tb
